// File: eew_master.sv
// two-wire bus master model that drives write frames into the eeprom
`timescale 1ns/10ps
module eew_master (
  input wire logic core_clk,
  output logic scl,
  output logic sda_m,
  input wire logic sda
);
  // clock parks high and data released between frames
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic start_cond();
    sda_m = 1'b1;
    tick(2);
    scl = 1'b1;
    tick(4);
    sda_m = 1'b0;
    tick(4);
    scl = 1'b0;
    tick(2);
  endtask
  task automatic stop_cond();
    sda_m = 1'b0;
    tick(2);
    scl = 1'b1;
    tick(4);
    sda_m = 1'b1;
    tick(6);
  endtask
  // data moves only while scl is low, so no false start or stop
  // long low phase: the slave lets go of its ack some five clocks after scl falls
  task automatic bit_cycle(input logic b, output logic s);
    sda_m = b;
    tick(5);
    scl = 1'b1;
    tick(1);
    s = sda;
    tick(1);
    scl = 1'b0;
    tick(1);
  endtask
  task automatic byte_out(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(d[i], s);
    end
    bit_cycle(1'b1, s);
    ack = ~s;
  endtask
endmodule

// File: eew_mem.sv
// small synchronous memory with registered read data
`timescale 1ns/10ps
module eew_mem #(
  parameter int DEPTH = 16,
  parameter int AW = 4,
  parameter int DW = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data
);
  logic [DW-1:0] mem [DEPTH];

  // array cells carry no reset, like real storage
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule

// File: eew_pkg.sv
// constants, types and state codes of the serial eeprom write path
// Notes on behaviour
// - Two address bytes follow the device select, high byte first, then low byte.
// - The low address byte picks a byte in a 256-byte block, high-byte bits 2..0 pick one of 8 blocks.
// - A write starts with START and a device select whose direction bit is 0, which is acknowledged.
// - Write protect high anywhere from START to the end of the second address byte blocks the write.
// - A byte write is one acknowledged data byte followed by STOP.
// - One to sixteen data bytes are each acknowledged and programmed together within one row.
// - After each data byte only the low four address bits count up, wrapping inside the row.
// - STOP after a write starts the self-timed programming cycle.
// - During programming all inputs are ignored and the device stays off the bus.
// - Programming ends at most 10 ms after the STOP that started it.
// - The select byte is a 4-bit type code, 3 bits matching the chip selects, then the direction bit.
// - After each 8-bit byte the receiver pulls data low during the ninth clock to acknowledge.
// - A select byte is not acknowledged while programming runs, and is acknowledged afterwards.
// - Data is sampled on each rising serial clock edge; it may change only while the clock is low.
package eew_pkg;
  localparam int ADDR_W = 11;
  localparam int DATA_W = 8;
  localparam int ROW_IDX_W = 4;
  localparam int ROW_W = ADDR_W - ROW_IDX_W;
  localparam int ARRAY_DEPTH = 2048;
  localparam int PAGE_DEPTH = 16;
  localparam int BLK_W = 3;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int CLK_KHZ = 20000;
  localparam int PROG_TIME_US = 10000;
  // longest time, so round down
  localparam int PROG_CYCLES_DEF = (PROG_TIME_US * CLK_KHZ) / 1000;
  localparam int CNT_W = 18;
  localparam logic [CNT_W-1:0] CNT_RST = 18'h00000;
  localparam logic [PAGE_DEPTH-1:0] MASK_RST = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_RST = 11'h000;
  // arbitrary type code value
  localparam logic [3:0] DEV_TYPE_DEF = 4'h5;
  localparam int NSYNC = 6;
  localparam logic [NSYNC-1:0] SYNC_RST = 6'h03;

  typedef enum logic [3:0] {
    ST_IDLE     = 4'b0000,
    ST_DEVSEL   = 4'b0001,
    ST_ACK_DEV  = 4'b0010,
    ST_ADDR_HI  = 4'b0011,
    ST_ACK_HI   = 4'b0100,
    ST_ADDR_LO  = 4'b0101,
    ST_ACK_LO   = 4'b0110,
    ST_DATA     = 4'b0111,
    ST_ACK_DATA = 4'b1000,
    ST_PROG     = 4'b1001
  } eew_state_t;
endpackage

// File: eew_top.sv
// two-wire eeprom slave write path with page latch and self-timed program cycle
`timescale 1ns/10ps
module eew_top #(
  parameter int PROG_CYCLES = eew_pkg::PROG_CYCLES_DEF,
  parameter logic [3:0] DEV_TYPE = eew_pkg::DEV_TYPE_DEF
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic scl,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  input wire logic write_protect_input,
  input wire logic [2:0] chip_select_inputs,
  output logic busy,
  input wire logic [eew_pkg::ADDR_W-1:0] peek_addr,
  output logic [eew_pkg::DATA_W-1:0] peek_data
);
  import eew_pkg::*;

  logic [NSYNC-1:0] s1_q, s2_q, s3_q, filt_q, filt_d;
  logic scl_p_q, sda_p_q;
  logic scl_f, sda_f, wp_f;
  logic [2:0] cs_f;
  logic scl_rise, scl_fall, start, stop, rx_state, pre_data;
  eew_state_t state_q, state_d;
  logic [3:0] bit_q, bit_d;
  logic [DATA_W-1:0] shift_q, shift_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [PAGE_DEPTH-1:0] mask_q, mask_d;
  logic [CNT_W-1:0] cnt_q, cnt_d, cnt_m1;
  logic wp_seen_q, wp_seen_d, oe_n_q, oe_n_d, busy_q, busy_d, sda_o_q;
  logic buf_we, arr_we, dev_take, hi_take, data_take, sel_match;
  logic [DATA_W-1:0] buf_rd;

  // three-stage sampler; a level counts only once stages two and three agree
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s1_q <= SYNC_RST;
      s2_q <= SYNC_RST;
      s3_q <= SYNC_RST;
      filt_q <= SYNC_RST;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      s1_q <= {chip_select_inputs, write_protect_input, sda_i, scl};
      s2_q <= s1_q;
      s3_q <= s2_q;
      filt_q <= filt_d;
      scl_p_q <= scl_f;
      sda_p_q <= sda_f;
    end
  end

  always_comb begin
    filt_d = (s2_q & s3_q) | (filt_q & (s2_q ^ s3_q));
  end

  assign scl_f = filt_q[0];
  assign sda_f = filt_q[1];
  assign wp_f = filt_q[2];
  assign cs_f = filt_q[5:3];
  assign scl_rise = scl_f & ~scl_p_q;
  assign scl_fall = ~scl_f & scl_p_q;
  assign start = scl_f & scl_p_q & sda_p_q & ~sda_f;
  assign stop = scl_f & scl_p_q & ~sda_p_q & sda_f;
  assign rx_state = (state_q == ST_DEVSEL) || (state_q == ST_ADDR_HI) ||
                    (state_q == ST_ADDR_LO) || (state_q == ST_DATA);
  assign pre_data = (state_q == ST_DEVSEL) || (state_q == ST_ACK_DEV) ||
                    (state_q == ST_ADDR_HI) || (state_q == ST_ACK_HI) ||
                    (state_q == ST_ADDR_LO);
  assign sel_match = (shift_q[7:4] == DEV_TYPE) && (shift_q[3:1] == cs_f) && !shift_q[0];
  assign dev_take = scl_fall && (bit_q == BITS_PER_BYTE) && (state_q == ST_DEVSEL);
  assign hi_take = scl_fall && (bit_q == BITS_PER_BYTE) && (state_q == ST_ADDR_HI);
  assign data_take = scl_fall && (bit_q == BITS_PER_BYTE) && (state_q == ST_DATA);
  assign cnt_m1 = cnt_q - 18'h00001;

  always_comb begin
    state_d = state_q;
    bit_d = bit_q;
    shift_d = shift_q;
    addr_d = addr_q;
    mask_d = mask_q;
    cnt_d = cnt_q;
    wp_seen_d = wp_seen_q;
    oe_n_d = oe_n_q;
    busy_d = busy_q;
    buf_we = 1'b0;
    arr_we = 1'b0;
    case (state_q)
      ST_PROG: begin
        // bus inputs are not even looked at while programming
        cnt_d = cnt_q + 18'h00001;
        oe_n_d = 1'b1;
        // latch is copied in the first 17 cycles, the rest is the fixed program time
        if (cnt_q >= 18'h00001 && cnt_q <= 18'h00010) begin
          arr_we = mask_q[cnt_m1[ROW_IDX_W-1:0]];
        end
        if (cnt_q == CNT_W'(PROG_CYCLES - 1)) begin
          state_d = ST_IDLE;
          busy_d = 1'b0;
          cnt_d = CNT_RST;
          mask_d = MASK_RST;
        end
      end
      default: begin
        if (start) begin
          state_d = ST_DEVSEL;
          bit_d = 4'h0;
          wp_seen_d = wp_f;
          mask_d = MASK_RST;
          oe_n_d = 1'b1;
        end else if (stop) begin
          oe_n_d = 1'b1;
          if ((state_q == ST_DATA || state_q == ST_ACK_DATA) && mask_q != MASK_RST) begin
            state_d = ST_PROG;
            busy_d = 1'b1;
            cnt_d = CNT_RST;
          end else begin
            state_d = ST_IDLE;
          end
        end else begin
          if (pre_data) begin
            wp_seen_d = wp_seen_q | wp_f;
          end
          if (scl_rise && rx_state && bit_q < BITS_PER_BYTE) begin
            shift_d = {shift_q[DATA_W-2:0], sda_f};
            bit_d = bit_q + 4'h1;
          end
          if (scl_fall) begin
            case (state_q)
              ST_DEVSEL: begin
                if (bit_q == BITS_PER_BYTE) begin
                  bit_d = 4'h0;
                  if (sel_match) begin
                    state_d = ST_ACK_DEV;
                    oe_n_d = 1'b0;
                  end else begin
                    state_d = ST_IDLE;
                  end
                end
              end
              ST_ADDR_HI: begin
                if (bit_q == BITS_PER_BYTE) begin
                  bit_d = 4'h0;
                  addr_d[ADDR_W-1:DATA_W] = shift_q[BLK_W-1:0];
                  state_d = ST_ACK_HI;
                  oe_n_d = 1'b0;
                end
              end
              ST_ADDR_LO: begin
                if (bit_q == BITS_PER_BYTE) begin
                  bit_d = 4'h0;
                  addr_d[DATA_W-1:0] = shift_q;
                  state_d = ST_ACK_LO;
                  oe_n_d = 1'b0;
                end
              end
              ST_DATA: begin
                if (bit_q == BITS_PER_BYTE) begin
                  bit_d = 4'h0;
                  state_d = ST_ACK_DATA;
                  if (!wp_seen_q) begin
                    buf_we = 1'b1;
                    mask_d[addr_q[ROW_IDX_W-1:0]] = 1'b1;
                    addr_d[ROW_IDX_W-1:0] = addr_q[ROW_IDX_W-1:0] + 4'h1;
                    oe_n_d = 1'b0;
                  end
                end
              end
              ST_ACK_DEV: begin
                oe_n_d = 1'b1;
                state_d = ST_ADDR_HI;
              end
              ST_ACK_HI: begin
                oe_n_d = 1'b1;
                state_d = ST_ADDR_LO;
              end
              ST_ACK_LO, ST_ACK_DATA: begin
                oe_n_d = 1'b1;
                state_d = ST_DATA;
              end
              default: begin
                oe_n_d = 1'b1;
              end
            endcase
          end
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
      bit_q <= 4'h0;
      shift_q <= '0;
      addr_q <= ADDR_RST;
      mask_q <= MASK_RST;
      cnt_q <= CNT_RST;
      wp_seen_q <= 1'b0;
      oe_n_q <= 1'b1;
      busy_q <= 1'b0;
      sda_o_q <= 1'b0;
    end else begin
      state_q <= state_d;
      bit_q <= bit_d;
      shift_q <= shift_d;
      addr_q <= addr_d;
      mask_q <= mask_d;
      cnt_q <= cnt_d;
      wp_seen_q <= wp_seen_d;
      oe_n_q <= oe_n_d;
      busy_q <= busy_d;
      sda_o_q <= 1'b0;
    end
  end

  // open drain: only ever pull low
  assign sda_o = sda_o_q;
  assign sda_oe_n = oe_n_q;
  assign busy = busy_q;

  eew_mem #(.DEPTH(PAGE_DEPTH), .AW(ROW_IDX_W), .DW(DATA_W)) u_page (
    .clk(core_clk),
    .nrst(nrst),
    .wr_en(buf_we),
    .wr_addr(addr_q[ROW_IDX_W-1:0]),
    .wr_data(shift_q),
    .rd_addr(cnt_q[ROW_IDX_W-1:0]),
    .rd_data(buf_rd)
  );

  eew_mem #(.DEPTH(ARRAY_DEPTH), .AW(ADDR_W), .DW(DATA_W)) u_array (
    .clk(core_clk),
    .nrst(nrst),
    .wr_en(arr_we),
    .wr_addr({addr_q[ADDR_W-1:ROW_IDX_W], cnt_m1[ROW_IDX_W-1:0]}),
    .wr_data(buf_rd),
    .rd_addr(peek_addr),
    .rd_data(peek_data)
  );

  a_prog_on_stop: assert property (@(posedge core_clk) disable iff (!nrst)
    (stop && (state_q == ST_DATA || state_q == ST_ACK_DATA) && mask_q != MASK_RST) |=>
      busy_q && state_q == ST_PROG)
    else $error("stop after data did not start programming");
  a_prog_bound: assert property (@(posedge core_clk) disable iff (!nrst)
    busy_q |-> cnt_q < CNT_W'(PROG_CYCLES))
    else $error("program cycle ran past its limit");
  a_prog_end: assert property (@(posedge core_clk) disable iff (!nrst)
    $fell(busy_q) |-> $past(cnt_q) == CNT_W'(PROG_CYCLES - 1))
    else $error("program cycle ended at the wrong count");
  a_prog_deaf: assert property (@(posedge core_clk) disable iff (!nrst)
    busy_q |=> oe_n_q && (state_q == ST_PROG || !busy_q))
    else $error("bus driven during programming");
  a_wp_nack: assert property (@(posedge core_clk) disable iff (!nrst)
    (data_take && wp_seen_q) |=> oe_n_q && mask_q == $past(mask_q))
    else $error("protected write was acknowledged");
  a_row_wrap: assert property (@(posedge core_clk) disable iff (!nrst)
    (data_take && !wp_seen_q) |=> addr_q[ADDR_W-1:ROW_IDX_W] ==
      $past(addr_q[ADDR_W-1:ROW_IDX_W]) &&
      addr_q[ROW_IDX_W-1:0] == $past(addr_q[ROW_IDX_W-1:0]) + 4'h1)
    else $error("address left its row");
  a_blk_select: assert property (@(posedge core_clk) disable iff (!nrst)
    hi_take |=> addr_q[ADDR_W-1:DATA_W] == $past(shift_q[BLK_W-1:0]))
    else $error("block bits not taken from high byte");
  a_sel_ack: assert property (@(posedge core_clk) disable iff (!nrst)
    dev_take |=> (!oe_n_q == $past(sel_match)) [*1] ##0 (oe_n_q || !sda_o))
    else $error("select acknowledge does not match decode");
  a_ack_hold: assert property (@(posedge core_clk) disable iff (!nrst)
    (state_q == ST_ACK_HI && !scl_fall && !start && !stop) |=> !oe_n_q)
    else $error("acknowledge released before ninth clock ended");
  a_sample_rise: assert property (@(posedge core_clk) disable iff (!nrst)
    (scl_rise && rx_state && bit_q < BITS_PER_BYTE && !start && !stop) |=>
      shift_q[0] == $past(sda_f) && bit_q == $past(bit_q) + 4'h1)
    else $error("data bit not sampled on rising clock");
endmodule

// File: tb_eew_top.sv
// self-checking bench for the eeprom write path
`timescale 1ns/10ps
module tb_eew_top;
  import eew_pkg::*;
  localparam int PCYC = 200;
  localparam logic [3:0] DTYPE = 4'h5;
  localparam logic [2:0] CSEL = 3'h5;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic wp = 1'b0;
  logic [2:0] cs = CSEL;
  logic [ADDR_W-1:0] peek_addr = '0;
  logic [DATA_W-1:0] peek_data;
  logic scl;
  logic sda_m;
  logic sda;
  logic sda_o;
  logic sda_oe_n;
  logic busy;
  logic [DATA_W-1:0] shadow [0:ARRAY_DEPTH-1];
  int mismatches = 0;
  int tests_run = 0;
  int busy_len = 0;
  always #25 core_clk = ~core_clk;
  // wired-and with pull-up: a released line reads high
  assign sda = sda_m & (sda_oe_n ? 1'b1 : sda_o);
  eew_master u_master (.core_clk(core_clk), .scl(scl), .sda_m(sda_m), .sda(sda));
  eew_top #(.PROG_CYCLES(PCYC), .DEV_TYPE(DTYPE)) uut (
    .core_clk(core_clk),
    .nrst(nrst),
    .scl(scl),
    .sda_i(sda),
    .sda_o(sda_o),
    .sda_oe_n(sda_oe_n),
    .write_protect_input(wp),
    .chip_select_inputs(cs),
    .busy(busy),
    .peek_addr(peek_addr),
    .peek_data(peek_data)
  );
  always @(negedge core_clk) begin
    if (busy === 1'b1) begin
      busy_len <= busy_len + 1;
    end
  end
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk_mem(input logic [ADDR_W-1:0] a);
    peek_addr = a;
    u_master.tick(2);
    chk("array byte", {8'h00, peek_data}, {8'h00, shadow[a]});
  endtask
  task automatic write_cmd(input logic [10:0] a, input int n, input logic [7:0] d0,
                           input logic wp_hi);
    logic ack;
    logic [10:0] cur;
    cur = a;
    u_master.start_cond();
    u_master.byte_out({DTYPE, CSEL, 1'b0}, ack);
    chk("select ack", {15'h0, ack}, 16'h0001);
    wp = wp_hi;
    u_master.byte_out({5'h00, a[10:8]}, ack);
    wp = 1'b0;
    chk("high address ack", {15'h0, ack}, 16'h0001);
    u_master.byte_out(a[7:0], ack);
    chk("low address ack", {15'h0, ack}, 16'h0001);
    for (int i = 0; i < n; i++) begin
      u_master.byte_out(d0 + 8'(i), ack);
      chk("data ack", {15'h0, ack}, {15'h0, ~wp_hi});
      shadow[cur] = wp_hi ? shadow[cur] : d0 + 8'(i);
      cur = {cur[10:4], cur[3:0] + 4'h1};
    end
    busy_len = 0;
    u_master.stop_cond();
  endtask
  task automatic poll_done(input int exp_len);
    logic ack;
    int nacks;
    nacks = 0;
    ack = 1'b0;
    for (int p = 0; p < 8 && ack !== 1'b1; p++) begin
      u_master.start_cond();
      u_master.byte_out({DTYPE, CSEL, 1'b0}, ack);
      nacks += int'(ack !== 1'b1);
      u_master.stop_cond();
    end
    chk("poll acked", {15'h0, ack}, 16'h0001);
    chk("poll refused while busy", {15'h0, nacks > 0}, {15'h0, exp_len > 0});
    chk("program cycle length", 16'(busy_len), 16'(exp_len));
  endtask
  task automatic byte_write();
    write_cmd(11'h1a3, 1, 8'h3b, 1'b0);
    poll_done(PCYC);
    write_cmd(11'h5a3, 1, 8'hc4, 1'b0);
    poll_done(PCYC);
    chk_mem(11'h1a3);
    chk_mem(11'h5a3);
  endtask
  // 18 bytes from offset 14: the last two land back on offsets 14 and 15
  task automatic page_wrap();
    write_cmd(11'h23e, 18, 8'h10, 1'b0);
    poll_done(PCYC);
    for (int i = 0; i < 16; i++) begin
      chk_mem({7'h23, 4'(i)});
    end
  endtask
  task automatic protect();
    write_cmd(11'h5a3, 1, 8'h77, 1'b1);
    poll_done(0);
    chk_mem(11'h5a3);
  endtask
  task automatic bad_select();
    logic [7:0] sel [3];
    logic ack;
    sel = '{{DTYPE, ~CSEL, 1'b0}, {~DTYPE, CSEL, 1'b0}, {DTYPE, CSEL, 1'b1}};
    foreach (sel[i]) begin
      u_master.start_cond();
      u_master.byte_out(sel[i], ack);
      chk("foreign select ack", {15'h0, ack}, 16'h0000);
      u_master.stop_cond();
    end
    // same select byte, but the chip select pins no longer agree with it
    cs = ~CSEL;
    u_master.start_cond();
    u_master.byte_out({DTYPE, CSEL, 1'b0}, ack);
    chk("select with moved pins", {15'h0, ack}, 16'h0000);
    u_master.stop_cond();
    cs = CSEL;
  endtask
  initial begin
    repeat (16) @(negedge core_clk);
    nrst = 1'b1;
    u_master.tick(4);
    chk("idle data enable", {15'h0, sda_oe_n}, 16'h0001);
    byte_write();
    page_wrap();
    protect();
    bad_select();
    wrap_up();
  end
  // whole run needs well under a tenth of this span
  initial begin
    #(PCYC * 50 * 400);
    mismatches++;
    wrap_up();
  end
endmodule
